// ---- core/imu_out_pkg.sv ----
// Shared constants and types for the inertial output register bank
package imu_out_pkg;

    // Register port geometry
    localparam int ADDR_W = 7;
    localparam int WORD_W = 16;
    localparam int RATE_AXES = 3;
    localparam int ACCEL_AXES = 2;

    // Byte addresses; each word spans this address and the next
    localparam logic [6:0] RATE_AXIS0_LOW_OFS  = 7'h04;
    localparam logic [6:0] RATE_AXIS0_HIGH_OFS = 7'h06;
    localparam logic [6:0] RATE_AXIS1_LOW_OFS  = 7'h08;
    localparam logic [6:0] RATE_AXIS1_HIGH_OFS = 7'h0A;
    localparam logic [6:0] RATE_AXIS2_LOW_OFS  = 7'h0C;
    localparam logic [6:0] RATE_AXIS2_HIGH_OFS = 7'h0E;
    localparam logic [6:0] ACCEL_AXIS0_LOW_OFS  = 7'h10;
    localparam logic [6:0] ACCEL_AXIS0_HIGH_OFS = 7'h12;
    localparam logic [6:0] ACCEL_AXIS1_LOW_OFS  = 7'h14;
    localparam logic [6:0] ACCEL_AXIS1_HIGH_OFS = 7'h16;

    // Field layout of a 32-bit sample: high word over low word
    localparam int HIGH_MSB = 31;
    localparam int HIGH_LSB = 16;
    localparam int LOW_MSB  = 15;
    localparam int LOW_LSB  = 0;

    // Reset and idle values
    localparam logic [31:0] SAMPLE_RESET  = 32'h0000_0000;
    localparam logic [15:0] UNMAPPED_READ = 16'h0000;

    // Scale of one high-word step, for reference by software models
    localparam int RATE_LSB_MILLIDEG_S = 100;
    localparam int ACCEL_LSB_MICRO_G   = 1250;

    // One coherent set of samples from the measurement pipeline
    typedef struct packed {
        logic [2:0][31:0] rate;
        logic [1:0][31:0] accel;
    } sample_t;

    // Host register request, one cycle per access
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [6:0]  addr;
        logic [15:0] wdata;
    } reg_req_t;

    // Register answer, valid one cycle after a read
    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } reg_resp_t;

endpackage

// ---- core/inertial_output_registers.sv ----
// Read-only bank of rate and acceleration output words
`timescale 1ns/1ns

// Overview of operation
// - Rate high word: signed, zero is 0x0000, 0.1 deg/s per step
// - Rate low word: all sixteen bits are extra fractional resolution
// - Accel high word: signed, +/-40 g, zero is 0x0000, 1.25 mg step
// - Accel low word: all sixteen bits are extra resolution
// - High word over low word forms one 32-bit signed sample
// - Rate axis 0: low word at 0x04, high word at 0x06
// - Rate axis 1: low word at 0x08, high word at 0x0A
// - Rate axis 2: low word at 0x0C, high word at 0x0E
// - Accel axis 0: low word at 0x10, high word at 0x12
// - Accel axis 1: low word at 0x14, high word at 0x16
module inertial_output_registers
(
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   sample_load,
    input  wire imu_out_pkg::sample_t   sample_in,
    input  wire imu_out_pkg::reg_req_t  req,
    output imu_out_pkg::reg_resp_t      resp,
    output logic                        wr_ignored
);

    // Odd byte addresses fall on the same word as the even one below
    function automatic logic [6:0] word_base
    (
        input logic [6:0] addr
    );
        return {addr[6:1], 1'b0};
    endfunction

    // Upper half of a sample carries the signed high word
    function automatic logic [15:0] high_half
    (
        input logic [31:0] v
    );
        return v[imu_out_pkg::HIGH_MSB:imu_out_pkg::HIGH_LSB];
    endfunction

    // Lower half carries only the extra resolution bits
    function automatic logic [15:0] low_half
    (
        input logic [31:0] v
    );
        return v[imu_out_pkg::LOW_MSB:imu_out_pkg::LOW_LSB];
    endfunction

    // Word decode; holes in the map read as zero
    function automatic logic [15:0] read_word
    (
        input logic [6:0]           addr,
        input imu_out_pkg::sample_t s
    );
        logic [6:0]  base;
        logic [15:0] word;
        base = word_base(addr);
        word = imu_out_pkg::UNMAPPED_READ;
        case (base)
            imu_out_pkg::RATE_AXIS0_LOW_OFS:
                word = low_half(s.rate[0]);
            imu_out_pkg::RATE_AXIS0_HIGH_OFS:
                word = high_half(s.rate[0]);
            imu_out_pkg::RATE_AXIS1_LOW_OFS:
                word = low_half(s.rate[1]);
            imu_out_pkg::RATE_AXIS1_HIGH_OFS:
                word = high_half(s.rate[1]);
            imu_out_pkg::RATE_AXIS2_LOW_OFS:
                word = low_half(s.rate[2]);
            imu_out_pkg::RATE_AXIS2_HIGH_OFS:
                word = high_half(s.rate[2]);
            imu_out_pkg::ACCEL_AXIS0_LOW_OFS:
                word = low_half(s.accel[0]);
            imu_out_pkg::ACCEL_AXIS0_HIGH_OFS:
                word = high_half(s.accel[0]);
            imu_out_pkg::ACCEL_AXIS1_LOW_OFS:
                word = low_half(s.accel[1]);
            imu_out_pkg::ACCEL_AXIS1_HIGH_OFS:
                word = high_half(s.accel[1]);
            default:
                word = imu_out_pkg::UNMAPPED_READ;
        endcase
        return word;
    endfunction

    imu_out_pkg::sample_t   samples_reg;
    imu_out_pkg::sample_t   samples_next;
    imu_out_pkg::reg_resp_t resp_reg;
    imu_out_pkg::reg_resp_t resp_next;
    logic                   wr_ignored_reg;
    logic                   wr_ignored_next;

    // Whole set loads at once so no axis mixes two sample times
    always_comb
    begin
        samples_next = samples_reg;
        if (sample_load)
        begin
            samples_next = sample_in;
        end
    end

    // Read answers from the stored set; writes touch nothing
    always_comb
    begin
        resp_next.valid = req.rd;
        resp_next.data  = imu_out_pkg::UNMAPPED_READ;
        if (req.rd)
        begin
            resp_next.data = read_word(req.addr, samples_reg);  // Stored set
        end
        wr_ignored_next = req.wr;
    end

    // Sample storage; high and low halves keep their full width
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < imu_out_pkg::RATE_AXES; i++)
            begin
                samples_reg.rate[i] <= imu_out_pkg::SAMPLE_RESET;
            end
            for (int j = 0; j < imu_out_pkg::ACCEL_AXES; j++)
            begin
                samples_reg.accel[j] <= imu_out_pkg::SAMPLE_RESET;
            end
        end
        else
        begin
            samples_reg <= samples_next;
        end
    end

    // Answer registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            resp_reg.valid <= 1'b0;
            resp_reg.data  <= imu_out_pkg::UNMAPPED_READ;
            wr_ignored_reg <= 1'b0;
        end
        else
        begin
            resp_reg       <= resp_next;
            wr_ignored_reg <= wr_ignored_next;
        end
    end

    assign resp       = resp_reg;
    assign wr_ignored = wr_ignored_reg;

    // Checks on the stored words and the read path

    property p_rate_high_signed;
        @(posedge clk) disable iff (!rst_n)
        sample_load |=>
            (($signed(samples_reg.rate[0][31:16]) < 0)
                == $past(sample_in.rate[0][31]))
            && ((samples_reg.rate[2][31:16] == 16'h0000)
                == ($past(sample_in.rate[2][31:16]) == 16'h0000));
    endproperty
    a_rate_high_signed:
        assert property (p_rate_high_signed)
        else $error("rate high word lost sign or zero");

    property p_rate_low_full;
        @(posedge clk) disable iff (!rst_n)
        sample_load |=>
            samples_reg.rate[1][15:0] == $past(sample_in.rate[1][15:0]);
    endproperty
    a_rate_low_full:
        assert property (p_rate_low_full)
        else $error("rate low word not loaded in full");

    property p_accel_high_signed;
        @(posedge clk) disable iff (!rst_n)
        sample_load |=>
            samples_reg.accel[0][31:16] == $past(sample_in.accel[0][31:16])
            && samples_reg.accel[1][31] == $past(sample_in.accel[1][31]);
    endproperty
    a_accel_high_signed:
        assert property (p_accel_high_signed)
        else $error("accel high word not loaded as signed value");

    property p_accel_low_full;
        @(posedge clk) disable iff (!rst_n)
        sample_load |=>
            samples_reg.accel[1][15:0] == $past(sample_in.accel[1][15:0]);
    endproperty
    a_accel_low_full:
        assert property (p_accel_low_full)
        else $error("accel low word not loaded in full");

    property p_pair_order;
        logic [31:0] full;
        @(posedge clk) disable iff (!rst_n)
        (sample_load, full = sample_in.rate[0]) ##1
        (req.rd && req.addr == imu_out_pkg::RATE_AXIS0_HIGH_OFS
            && !sample_load)
        |=> resp.data == full[31:16];
    endproperty
    a_pair_order:
        assert property (p_pair_order)
        else $error("high word is not upper half of sample");

    property p_map_rate0;
        @(posedge clk) disable iff (!rst_n)
        req.rd && word_base(req.addr) == imu_out_pkg::RATE_AXIS0_LOW_OFS
        |=> resp.valid && resp.data == $past(samples_reg.rate[0][15:0]);
    endproperty
    a_map_rate0:
        assert property (p_map_rate0)
        else $error("rate axis 0 low word misplaced");

    property p_map_rate1;
        @(posedge clk) disable iff (!rst_n)
        req.rd && req.addr == imu_out_pkg::RATE_AXIS1_HIGH_OFS
        |=> resp.data == $past(samples_reg.rate[1][31:16]);
    endproperty
    a_map_rate1:
        assert property (p_map_rate1)
        else $error("rate axis 1 high word misplaced");

    property p_map_rate2;
        @(posedge clk) disable iff (!rst_n)
        req.rd && req.addr == imu_out_pkg::RATE_AXIS2_LOW_OFS
        |=> resp.data == $past(samples_reg.rate[2][15:0]);
    endproperty
    a_map_rate2:
        assert property (p_map_rate2)
        else $error("rate axis 2 low word misplaced");

    property p_map_accel0;
        @(posedge clk) disable iff (!rst_n)
        req.rd && word_base(req.addr) == imu_out_pkg::ACCEL_AXIS0_HIGH_OFS
        |=> resp.data == $past(samples_reg.accel[0][31:16]);
    endproperty
    a_map_accel0:
        assert property (p_map_accel0)
        else $error("accel axis 0 high word misplaced");

    property p_map_accel1;
        @(posedge clk) disable iff (!rst_n)
        req.rd && req.addr == imu_out_pkg::ACCEL_AXIS1_LOW_OFS
        |=> resp.data == $past(samples_reg.accel[1][15:0]);
    endproperty
    a_map_accel1:
        assert property (p_map_accel1)
        else $error("accel axis 1 low word misplaced");

    property p_hold_no_load;
        @(posedge clk) disable iff (!rst_n)
        !sample_load |=> $stable(samples_reg);
    endproperty
    a_hold_no_load:
        assert property (p_hold_no_load)
        else $error("stored samples changed without a load");

    property p_write_ignored;
        @(posedge clk) disable iff (!rst_n)
        req.wr && !req.rd && !sample_load
        |=> wr_ignored && !resp.valid && $stable(samples_reg);
    endproperty
    a_write_ignored:
        assert property (p_write_ignored)
        else $error("host write was not ignored");

    property p_unmapped_zero;
        @(posedge clk) disable iff (!rst_n)
        req.rd && (req.addr < imu_out_pkg::RATE_AXIS0_LOW_OFS
            || word_base(req.addr) > imu_out_pkg::ACCEL_AXIS1_HIGH_OFS)
        |=> resp.valid && resp.data == imu_out_pkg::UNMAPPED_READ;
    endproperty
    a_unmapped_zero:
        assert property (p_unmapped_zero)
        else $error("unmapped read not zero");

    property p_map_rate0_high;
        @(posedge clk) disable iff (!rst_n)
        req.rd && word_base(req.addr) == imu_out_pkg::RATE_AXIS0_HIGH_OFS
        |=> resp.data == $past(samples_reg.rate[0][31:16]);
    endproperty
    a_map_rate0_high:
        assert property (p_map_rate0_high)
        else $error("rate axis 0 high word misplaced");

    property p_map_rate1_low;
        @(posedge clk) disable iff (!rst_n)
        req.rd && word_base(req.addr) == imu_out_pkg::RATE_AXIS1_LOW_OFS
        |=> resp.data == $past(samples_reg.rate[1][15:0]);
    endproperty
    a_map_rate1_low:
        assert property (p_map_rate1_low)
        else $error("rate axis 1 low word misplaced");

    property p_map_accel0_low;
        @(posedge clk) disable iff (!rst_n)
        req.rd && word_base(req.addr) == imu_out_pkg::ACCEL_AXIS0_LOW_OFS
        |=> resp.data == $past(samples_reg.accel[0][15:0]);
    endproperty
    a_map_accel0_low:
        assert property (p_map_accel0_low)
        else $error("accel axis 0 low word misplaced");

    property p_map_accel1_high;
        @(posedge clk) disable iff (!rst_n)
        req.rd && word_base(req.addr) == imu_out_pkg::ACCEL_AXIS1_HIGH_OFS
        |=> resp.data == $past(samples_reg.accel[1][31:16]);
    endproperty
    a_map_accel1_high:
        assert property (p_map_accel1_high)
        else $error("accel axis 1 high word misplaced");

    // The write flag must not outlive its single cycle
    property p_write_flag_idle;
        @(posedge clk) disable iff (!rst_n)
        !req.wr |=> !wr_ignored;
    endproperty
    a_write_flag_idle:
        assert property (p_write_flag_idle)
        else $error("write flag raised without a write");

endmodule

// ---- verif/host_reader.sv ----
// Host model that reads and writes the output register bank
`timescale 1ns/1ns
module host_reader
(
    input  wire imu_out_pkg::reg_resp_t resp,
    input  wire logic                   clk,
    output imu_out_pkg::reg_req_t       req
);
    // Bus idle from time zero
    initial req = '0;

    // One access, held to its taking edge; answer seen a cycle later
    task automatic access(input logic rd, input logic wr,
                          input logic [6:0] a, input logic [15:0] wd,
                          output logic [15:0] d, output logic v);
        @(posedge clk);
        req <= '{rd: rd, wr: wr, addr: a, wdata: wd};
        @(posedge clk);
        req <= '0;
        #1;
        v = resp.valid;
        d = resp.data;
    endtask

    // Two reads joined; a load between them may tear the pair
    task automatic read_sample(input logic [6:0] lo,
                               output logic [31:0] s);
        logic [15:0] l;
        logic [15:0] h;
        logic        v;
        access(1'b1, 1'b0, lo, 16'h0000, l, v);
        access(1'b1, 1'b0, lo + 7'h02, 16'h0000, h, v);
        s = {h, l};
    endtask
endmodule

// ---- verif/inertial_output_registers_bench.sv ----
// Self-checking bench for the inertial output register bank
`timescale 1ns/1ns
`define CHK(n, e, g) \
    begin samples_checked++; if ((e) !== (g)) begin fails++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module inertial_output_registers_bench;
    logic                   clk = 1'b0;
    logic                   rst_n = 1'b0;
    logic                   sample_load = 1'b0;
    imu_out_pkg::sample_t   sample_in = '0;
    imu_out_pkg::reg_req_t  req;
    imu_out_pkg::reg_resp_t resp;
    logic                   wr_ignored;
    int                     fails = 0;
    int                     samples_checked = 0;
    // Full-scale and sign-edge words in s1; some halves repeat
    logic [4:0][31:0] s1 = {32'h8300_0002, 32'h7D00_8000,
        32'hB1E0_0001, 32'hFFFF_FFFF, 32'h4E20_1234};
    logic [4:0][31:0] s2 = {32'h0000_0001, 32'hFFFF_FFFE,
        32'h0001_0000, 32'h0000_FFFF, 32'h0002_0003};

    always #4 clk = ~clk;

    inertial_output_registers dut (.clk(clk), .rst_n(rst_n),
        .sample_load(sample_load), .sample_in(sample_in),
        .req(req), .resp(resp), .wr_ignored(wr_ignored));
    host_reader host (.clk(clk), .resp(resp), .req(req));

    // One-cycle load strobe with a full set of samples
    task automatic load(input logic [4:0][31:0] s);
        @(posedge clk);
        sample_load <= 1'b1;
        sample_in <= '{rate: s[2:0], accel: s[4:3]};
        @(posedge clk);
        sample_load <= 1'b0;
    endtask

    // Every word at its even and its odd byte address
    task automatic check_all(input logic [4:0][31:0] s);
        logic [15:0] d;
        logic [15:0] e;
        logic        v;
        for (int i = 0; i < 20; i++)
        begin
            e = i[1] ? s[i/4][31:16] : s[i/4][15:0];
            host.access(1'b1, 1'b0, 7'(4 + i), 16'h0000, d, v);
            `CHK("valid", 1'b1, v)
            `CHK("word", e, d)
        end
    endtask

    // Reset leaves every stored word at zero
    task automatic test_reset(input string t);
        check_all('0);
        $display("test %s done", t);
    endtask

    // A loaded set at every word; holes on both sides read zero
    task automatic test_map();
        logic [15:0] d;
        logic        v;
        load(s1);
        check_all(s1);
        host.access(1'b1, 1'b0, 7'h03, 16'h0000, d, v);
        `CHK("hole below", 16'h0000, d)
        host.access(1'b1, 1'b0, 7'h18, 16'h0000, d, v);
        `CHK("hole above", 16'h0000, d)
        `CHK("hole valid", 1'b1, v)
        $display("test map done");
    endtask

    // Host joins high over low for each axis
    task automatic test_pair();
        logic [31:0] w;
        for (int a = 0; a < 5; a++)
        begin
            host.read_sample(7'(4 + 4 * a), w);
            `CHK("pair", s1[a], w)
        end
        $display("test pair done");
    endtask

    // Writes change nothing; a read with a write is still answered
    task automatic test_write();
        logic [15:0] d;
        logic        v;
        host.access(1'b0, 1'b1, 7'h06, 16'h5555, d, v);
        `CHK("wr_ignored", 1'b1, wr_ignored)
        `CHK("write answer", 1'b0, v)
        host.access(1'b1, 1'b1, 7'h12, 16'hAAAA, d, v);
        `CHK("rd wr valid", 1'b1, v)
        `CHK("rd wr data", s1[3][31:16], d)
        `CHK("rd wr ignored", 1'b1, wr_ignored)
        check_all(s1);
        `CHK("wr_ignored idle", 1'b0, wr_ignored)
        $display("test write done");
    endtask

    // Read on a load edge sees the old set, one edge later the new
    task automatic test_load_edge();
        logic [15:0] d;
        logic        v;
        fork
            host.access(1'b1, 1'b0, 7'h04, 16'h0000, d, v);
            load(s2);
        join
        `CHK("same edge", s1[0][15:0], d)
        check_all(s2);
        fork
            load(s1);
            begin
                @(posedge clk);
                host.access(1'b1, 1'b0, 7'h06, 16'h0000, d, v);
            end
        join
        `CHK("next edge", s1[0][31:16], d)
        $display("test load done");
    endtask

    // Reset in mid-run clears the loaded set
    task automatic test_mid_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        test_reset("second reset");
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Hang guard, far beyond the few hundred cycles the tests need
    initial
    begin
        #20000;
        fails++;
        summarize();
    end

    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        test_reset("reset");
        test_map();
        test_pair();
        test_write();
        test_load_edge();
        test_mid_reset();
        summarize();
    end
endmodule
